// ### src/csr_params.svh
// Offsets, field positions, reset values and timing counts of the special registers
`ifndef CSR_PARAMS_SVH
`define CSR_PARAMS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define CSR_A_IND_ZERO 7'h00
`define CSR_A_PTR_ZERO 7'h01
`define CSR_A_IND_ONE 7'h02
`define CSR_A_PTR_ONE 7'h03
`define CSR_A_BANK 7'h04
`define CSR_A_WORK 7'h05
`define CSR_A_PC_L 7'h06
`define CSR_A_FLAGS 7'h0A
`define CSR_A_PORT_A 7'h10
`define CSR_A_PORT_A_DIR 7'h11
`define CSR_A_PORT_B 7'h14
`define CSR_A_PORT_B_DIR 7'h15
`define CSR_A_SYSCTL0 7'h1A
`define CSR_A_GP_BASE 7'h40

// ****************************************************************
// Field positions
// ****************************************************************
`define CSR_F_WDT 5
`define CSR_F_SLEEP 4
`define CSR_F_OV 3
`define CSR_F_Z 2
`define CSR_F_AC 1
`define CSR_F_C 0
`define CSR_F_DIV_HI 3
`define CSR_F_DIV_LO 2
`define CSR_F_XTAL_LP 1
`define CSR_F_SPEED 0

// ****************************************************************
// Reset values and counts
// ****************************************************************
`define CSR_RST_BYTE 8'h00
`define CSR_RST_DIR 8'hFF
`define CSR_RST_CTRL 4'h0
`define CSR_DUMMY_CYCLES 1

`endif

// ### src/csr_pkg.sv
// Types shared by the special register block
`default_nettype none
package csr_pkg;
    typedef enum logic [2:0] {
        CSR_ALU_ADD,
        CSR_ALU_SUB,
        CSR_ALU_LOGIC,
        CSR_ALU_RLC,
        CSR_ALU_RRC
    } csr_alu_t;
endpackage
`default_nettype wire

// ### src/csr_top.sv
// Special-function register bank: pointers, banks, flags, ports and control
//
// Our own choices: the plain strobed port and the placing of the registers.
`include "csr_params.svh"
`default_nettype none

module csr_top #(
    parameter int PC_W = 10,
    parameter int GP_DEPTH = 64
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // Register port
    input wire logic [6:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // Single-bit set and clear
    input wire logic bit_op_i,
    input wire logic [6:0] bit_addr_i,
    input wire logic [2:0] bit_pos_i,
    input wire logic bit_set_i,
    // Arithmetic flag update
    input wire logic alu_valid_i,
    input wire csr_pkg::csr_alu_t alu_kind_i,
    input wire logic [7:0] alu_a_i,
    input wire logic [7:0] alu_b_i,
    // System events
    input wire logic wdt_timeout_i,
    input wire logic clrwdt_i,
    input wire logic stop_i,
    input wire logic soft_reset_i,
    input wire logic soft_reset_wdt_lp_i,
    input wire logic pc_step_i,
    // Program counter and flags
    output logic [PC_W-1:0] pc_o,
    output logic jump_o,
    output logic dummy_cycle_o,
    output logic [7:0] flags_o,
    // Port pins
    input wire logic [7:0] pa_pin_i,
    output logic [7:0] pa_out_o,
    output logic [7:0] pa_oe_o,
    input wire logic [7:0] pb_pin_i,
    output logic [7:0] pb_out_o,
    output logic [7:0] pb_oe_o,
    // Clock and divider control
    output logic div_out0_en_o,
    output logic div_out1_en_o,
    output logic xtal_low_power_o,
    output logic slow_clock_sel_o,
    output logic fast_rc_run_o
);
    import csr_pkg::*;

    localparam int IDX_W = $clog2(GP_DEPTH);

    typedef struct packed {
        logic [7:0] work;
        logic [7:0] ptr0;
        logic [7:0] ptr1;
        logic [7:0] pa;
        logic [7:0] port_a_direction;
        logic [7:0] pb;
        logic [7:0] port_b_direction;
        logic [7:0] rdata;
        logic bank;
        logic [3:0] ctrl;
        logic wdt_f;
        logic sleep_f;
        logic ov;
        logic z;
        logic ac;
        logic c;
        logic [PC_W-1:0] pc;
        logic jump;
        logic dummy;
        logic [2:0][7:0] pa_sync;
        logic [2:0][7:0] pb_sync;
        logic [7:0] pa_pin;
        logic [7:0] pb_pin;
        logic [7:0] pa_oe;
        logic [7:0] pb_oe;
        logic div0;
        logic div1;
        logic [1:0][GP_DEPTH-1:0][7:0] ram;
    } csr_state_t;

    csr_state_t st;
    csr_state_t next_st;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic gp_hit(input logic [7:0] a);
        gp_hit = (a >= {1'b0, `CSR_A_GP_BASE}) &&
                 ((a - {1'b0, `CSR_A_GP_BASE}) < 8'(GP_DEPTH));
    endfunction

    function automatic logic [IDX_W-1:0] gp_idx(input logic [7:0] a);
        logic [7:0] d;
        d = a - {1'b0, `CSR_A_GP_BASE};
        gp_idx = d[IDX_W-1:0];
    endfunction

    // Pin bit follows the sync pair only where both stages agree
    function automatic logic [7:0] pin_filter(input logic [7:0] s1, input logic [7:0] s2,
                                              input logic [7:0] held);
        pin_filter = (~(s1 ^ s2) & s1) | ((s1 ^ s2) & held);
    endfunction

    function automatic logic [7:0] port_view(input logic [7:0] dir, input logic [7:0] pin,
                                             input logic [7:0] latch);
        port_view = (dir & pin) | (~dir & latch);
    endfunction

    // {result, ov, ac, c}
    function automatic logic [10:0] alu_eval(input csr_alu_t k, input logic [7:0] a,
                                             input logic [7:0] b, input logic cin);
        logic [7:0] bb;
        logic ci;
        logic [8:0] full;
        logic [4:0] low;
        logic [7:0] upto7;
        bb = (k == CSR_ALU_SUB) ? ~b : b;
        ci = (k == CSR_ALU_SUB);
        full = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
        low = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
        upto7 = {1'b0, a[6:0]} + {1'b0, bb[6:0]} + {7'h00, ci};
        case (k)
            CSR_ALU_ADD, CSR_ALU_SUB: begin
                alu_eval = {full[7:0], upto7[7] ^ full[8], low[4], full[8]};
            end
            CSR_ALU_RLC: begin
                alu_eval = {a[6:0], cin, 1'b0, 1'b0, a[7]};
            end
            CSR_ALU_RRC: begin
                alu_eval = {cin, a[7:1], 1'b0, 1'b0, a[0]};
            end
            default: begin
                alu_eval = {a, 3'b000};
            end
        endcase
    endfunction

    // Special area decoded without the bank bit
    function automatic logic [7:0] reg_read(input csr_state_t s, input logic [6:0] a,
                                            input logic [7:0] w0, input logic [7:0] w1);
        case (a)
            `CSR_A_IND_ZERO: reg_read = w0;
            `CSR_A_PTR_ZERO: reg_read = s.ptr0;
            `CSR_A_IND_ONE: reg_read = w1;
            `CSR_A_PTR_ONE: reg_read = s.ptr1;
            `CSR_A_BANK: reg_read = {7'h00, s.bank};
            `CSR_A_WORK: reg_read = s.work;
            `CSR_A_PC_L: reg_read = s.pc[7:0];
            `CSR_A_FLAGS: reg_read = {2'b00, s.wdt_f, s.sleep_f, s.ov, s.z, s.ac, s.c};
            `CSR_A_PORT_A: reg_read = port_view(s.port_a_direction, s.pa_pin, s.pa);
            `CSR_A_PORT_A_DIR: reg_read = s.port_a_direction;
            `CSR_A_PORT_B: reg_read = port_view(s.port_b_direction, s.pb_pin, s.pb);
            `CSR_A_PORT_B_DIR: reg_read = s.port_b_direction;
            `CSR_A_SYSCTL0: reg_read = {4'h0, s.ctrl};
            default: begin
                if (gp_hit({1'b0, a})) begin
                    reg_read = s.ram[0][gp_idx({1'b0, a})];
                end else begin
                    reg_read = `CSR_RST_BYTE;
                end
            end
        endcase
    endfunction

    // ****************************************************************
    // Next state
    // ****************************************************************
    logic [7:0] ind0_word;
    logic [7:0] ind1_word;
    logic [7:0] alu_res;

    always_comb begin
        logic acc_en;
        logic [6:0] acc_a;
        logic [7:0] cur;
        logic [7:0] mask;
        logic [7:0] val;
        logic [7:0] wv;
        logic [10:0] alu;
        acc_en = wr_i | bit_op_i;
        acc_a = wr_i ? addr_i : bit_addr_i;
        mask = 8'h00;
        val = 8'h00;
        cur = 8'h00;
        wv = 8'h00;
        ind0_word = gp_hit(st.ptr0) ? st.ram[0][gp_idx(st.ptr0)] : 8'h00;
        ind1_word = gp_hit(st.ptr1) ? st.ram[st.bank][gp_idx(st.ptr1)] : 8'h00;
        alu = alu_eval(alu_kind_i, alu_a_i, alu_b_i, st.c);
        alu_res = alu[10:3];
        next_st = st;
        next_st.jump = 1'b0;
        next_st.dummy = st.jump;
        // Second and third sync stages vote before a pin change counts
        next_st.pa_sync = {st.pa_sync[1:0], pa_pin_i};
        next_st.pb_sync = {st.pb_sync[1:0], pb_pin_i};
        next_st.pa_pin = pin_filter(st.pa_sync[1], st.pa_sync[2], st.pa_pin);
        next_st.pb_pin = pin_filter(st.pb_sync[1], st.pb_sync[2], st.pb_pin);
        if (rd_i) begin
            next_st.rdata = reg_read(st, addr_i, ind0_word, ind1_word);
        end
        // Bit ops reuse the write path as read-modify-write
        if (wr_i) begin
            mask = 8'hFF;
            val = wdata_i;
        end else if (bit_op_i) begin
            mask = 8'h01 << bit_pos_i;
            val = bit_set_i ? 8'hFF : 8'h00;
        end
        case (acc_a)
            `CSR_A_PORT_A: cur = st.pa;
            `CSR_A_PORT_B: cur = st.pb;
            default: cur = reg_read(st, acc_a, ind0_word, ind1_word);
        endcase
        wv = (cur & ~mask) | (val & mask);
        if (pc_step_i && !st.dummy) begin
            next_st.pc = st.pc + PC_W'(1);
        end
        // Bus data, or for a bit op the current value with one bit replaced, reaches the addressed register
        if (acc_en) begin
            case (acc_a)
                `CSR_A_IND_ZERO: begin
                    if (gp_hit(st.ptr0)) begin
                        next_st.ram[0][gp_idx(st.ptr0)] = wv;
                    end
                end
                `CSR_A_PTR_ZERO: next_st.ptr0 = wv;
                `CSR_A_IND_ONE: begin
                    if (gp_hit(st.ptr1)) begin
                        next_st.ram[st.bank][gp_idx(st.ptr1)] = wv;
                    end
                end
                `CSR_A_PTR_ONE: next_st.ptr1 = wv;
                `CSR_A_BANK: next_st.bank = wv[0];
                `CSR_A_WORK: next_st.work = wv;
                `CSR_A_PC_L: begin
                    next_st.pc = {st.pc[PC_W-1:8], wv};
                    next_st.jump = 1'b1;
                end
                `CSR_A_FLAGS: begin
                    {next_st.ov, next_st.z, next_st.ac, next_st.c} = wv[3:0];
                end
                `CSR_A_PORT_A: next_st.pa = wv;
                `CSR_A_PORT_A_DIR: next_st.port_a_direction = wv;
                `CSR_A_PORT_B: next_st.pb = wv;
                `CSR_A_PORT_B_DIR: next_st.port_b_direction = wv;
                `CSR_A_SYSCTL0: next_st.ctrl = wv[3:0];
                default: begin
                    if (gp_hit({1'b0, acc_a})) begin
                        next_st.ram[0][gp_idx({1'b0, acc_a})] = wv;
                    end
                end
            endcase
        end
        // Hardware flag updates override a software write in the same cycle
        if (alu_valid_i) begin
            case (alu_kind_i)
                CSR_ALU_ADD, CSR_ALU_SUB: begin
                    next_st.ov = alu[2];
                    next_st.ac = alu[1];
                    next_st.c = alu[0];
                    next_st.z = (alu_res == 8'h00);
                end
                CSR_ALU_LOGIC: next_st.z = (alu_res == 8'h00);
                CSR_ALU_RLC, CSR_ALU_RRC: next_st.c = alu[0];
                default: next_st.z = st.z;
            endcase
        end
        // Call and interrupt entry have no path into the flags
        if (clrwdt_i) begin
            next_st.wdt_f = 1'b0;
            next_st.sleep_f = 1'b0;
        end
        if (stop_i) begin
            next_st.wdt_f = 1'b0;
            next_st.sleep_f = 1'b1;
        end
        if (wdt_timeout_i) begin
            next_st.wdt_f = 1'b1;
        end
        if (soft_reset_i && !soft_reset_wdt_lp_i) begin
            next_st.bank = 1'b0;
        end
        next_st.pa_oe = ~next_st.port_a_direction;
        next_st.pb_oe = ~next_st.port_b_direction;
        // Reserved code 01 leaves both dividers off
        next_st.div0 = next_st.ctrl[`CSR_F_DIV_HI];
        next_st.div1 = next_st.ctrl[`CSR_F_DIV_HI] & next_st.ctrl[`CSR_F_DIV_LO];
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            st <= '0;
            st.port_a_direction <= `CSR_RST_DIR;
            st.port_b_direction <= `CSR_RST_DIR;
            st.ctrl <= `CSR_RST_CTRL;
            st.bank <= 1'b0;
            st.wdt_f <= 1'b0;
            st.sleep_f <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    assign rdata_o = st.rdata;
    assign pc_o = st.pc;
    assign jump_o = st.jump;
    assign dummy_cycle_o = st.dummy;
    assign flags_o = {2'b00, st.wdt_f, st.sleep_f, st.ov, st.z, st.ac, st.c};
    assign pa_out_o = st.pa;
    assign pa_oe_o = st.pa_oe;
    assign pb_out_o = st.pb;
    assign pb_oe_o = st.pb_oe;
    assign div_out0_en_o = st.div0;
    assign div_out1_en_o = st.div1;
    assign xtal_low_power_o = st.ctrl[`CSR_F_XTAL_LP];
    assign slow_clock_sel_o = st.ctrl[`CSR_F_SPEED];
    assign fast_rc_run_o = ~st.ctrl[`CSR_F_SPEED];

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (reset_i);

    logic pcl_wr;
    logic flags_quiet;
    assign pcl_wr = wr_i && addr_i == `CSR_A_PC_L;
    assign flags_quiet = !clrwdt_i && !stop_i && !wdt_timeout_i;

    a_pcl_low_byte: assert property (pcl_wr |=>
        pc_o[7:0] == $past(wdata_i) && pc_o[PC_W-1:8] == $past(st.pc[PC_W-1:8]))
        else $error("pc_l write did not replace only the low byte");
    a_dummy_after: assert property (pcl_wr |=> jump_o ##1 dummy_cycle_o)
        else $error("no dummy cycle after jump");
    a_bank_upper: assert property (rd_i && addr_i == `CSR_A_BANK |=> rdata_o[7:1] == 7'h00)
        else $error("bank register upper bits not zero");
    a_ind0_bank0: assert property (rd_i && addr_i == `CSR_A_IND_ZERO |=>
        rdata_o == $past(ind0_word))
        else $error("pointer zero read wrong word");
    a_ind1_bank: assert property (rd_i && addr_i == `CSR_A_IND_ONE && st.bank |=>
        rdata_o == $past(ind1_word))
        else $error("pointer one read ignored bank");
    a_bank_keep: assert property (soft_reset_i && soft_reset_wdt_lp_i && !wr_i && !bit_op_i
        |=> st.bank == $past(st.bank))
        else $error("low-power watchdog reset changed bank");
    a_flag_write: assert property (wr_i && addr_i == `CSR_A_FLAGS && flags_quiet |=>
        flags_o[5:4] == $past(flags_o[5:4]) && flags_o[7:6] == 2'b00)
        else $error("flag write touched system flags");
    a_wdt_set: assert property (wdt_timeout_i |=> flags_o[`CSR_F_WDT])
        else $error("watchdog flag not set");
    a_sleep_set: assert property (stop_i && !clrwdt_i |=> flags_o[`CSR_F_SLEEP])
        else $error("sleep flag not set by stop");
    a_zero_flag: assert property (alu_valid_i && alu_kind_i == CSR_ALU_LOGIC |=>
        flags_o[`CSR_F_Z] == ($past(alu_res) == 8'h00))
        else $error("zero flag wrong");
    a_dir_oe: assert property (wr_i && addr_i == `CSR_A_PORT_A_DIR |=>
        pa_oe_o == ~$past(wdata_i))
        else $error("direction did not drive enable");

    c_jump: cover property (pcl_wr ##1 jump_o ##1 dummy_cycle_o);
    c_bank1_read: cover property (rd_i && addr_i == `CSR_A_IND_ONE && st.bank);
    c_wdt_timeout: cover property (wdt_timeout_i ##1 flags_o[`CSR_F_WDT]);
    c_bit_op: cover property (bit_op_i && bit_addr_i == `CSR_A_PORT_A_DIR);
endmodule
`default_nettype wire

// ### test/csr_top_tb.sv
// Self-checking testbench for the special-function register bank
`include "csr_params.svh"
`default_nettype none

module csr_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import csr_pkg::*;

    // ****************************************************************
    // Stimulus and observation signals
    // ****************************************************************
    logic mclk_i, reset_i, wr_i, rd_i, bit_op_i, bit_set_i, alu_valid_i;
    logic [6:0] addr_i, bit_addr_i;
    logic [7:0] wdata_i, rdata_o, alu_a_i, alu_b_i, flags_o, pa_pin_i, pb_pin_i;
    logic [7:0] pa_out_o, pa_oe_o, pb_out_o, pb_oe_o, rd_val;
    logic [2:0] bit_pos_i;
    csr_alu_t alu_kind_i;
    logic wdt_timeout_i, clrwdt_i, stop_i, soft_reset_i, soft_reset_wdt_lp_i, pc_step_i;
    logic [9:0] pc_o;
    logic jump_o, dummy_cycle_o, div_out0_en_o, div_out1_en_o;
    logic xtal_low_power_o, slow_clock_sel_o, fast_rc_run_o;
    int miscompares = 0;
    int n_tests = 0;

    csr_top uut (.mclk_i(mclk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .bit_op_i(bit_op_i),
        .bit_addr_i(bit_addr_i), .bit_pos_i(bit_pos_i), .bit_set_i(bit_set_i),
        .alu_valid_i(alu_valid_i), .alu_kind_i(alu_kind_i), .alu_a_i(alu_a_i),
        .alu_b_i(alu_b_i), .wdt_timeout_i(wdt_timeout_i), .clrwdt_i(clrwdt_i),
        .stop_i(stop_i), .soft_reset_i(soft_reset_i),
        .soft_reset_wdt_lp_i(soft_reset_wdt_lp_i), .pc_step_i(pc_step_i), .pc_o(pc_o),
        .jump_o(jump_o), .dummy_cycle_o(dummy_cycle_o), .flags_o(flags_o),
        .pa_pin_i(pa_pin_i), .pa_out_o(pa_out_o), .pa_oe_o(pa_oe_o), .pb_pin_i(pb_pin_i),
        .pb_out_o(pb_out_o), .pb_oe_o(pb_oe_o), .div_out0_en_o(div_out0_en_o),
        .div_out1_en_o(div_out1_en_o), .xtal_low_power_o(xtal_low_power_o),
        .slow_clock_sel_o(slow_clock_sel_o), .fast_rc_run_o(fast_rc_run_o));

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic finish_test();
        if (miscompares == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask

    // Data is registered at the edge after the strobe and held until the next read; sample it there
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        rd_val = rdata_o;
        chk(rd_val, exp);
    endtask

    task automatic settle();
        repeat (2) @(posedge mclk_i);
        #1;
    endtask

    task automatic alu(input csr_alu_t k, input logic [7:0] a, input logic [7:0] b);
        @(posedge mclk_i);
        alu_valid_i <= 1'b1;
        alu_kind_i <= k;
        alu_a_i <= a;
        alu_b_i <= b;
        @(posedge mclk_i);
        alu_valid_i <= 1'b0;
    endtask

    // Pulses {timeout, clear, stop, soft reset}
    task automatic ev(input logic [3:0] s, input logic lp);
        @(posedge mclk_i);
        {wdt_timeout_i, clrwdt_i, stop_i, soft_reset_i} <= s;
        soft_reset_wdt_lp_i <= lp;
        @(posedge mclk_i);
        {wdt_timeout_i, clrwdt_i, stop_i, soft_reset_i} <= 4'h0;
    endtask

    task automatic bitop(input logic [6:0] a, input logic [2:0] p, input logic s);
        @(posedge mclk_i);
        bit_op_i <= 1'b1;
        bit_addr_i <= a;
        bit_pos_i <= p;
        bit_set_i <= s;
        @(posedge mclk_i);
        bit_op_i <= 1'b0;
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        rd_chk(`CSR_A_FLAGS, 8'h00);
        rd_chk(`CSR_A_BANK, 8'h00);
        rd_chk(`CSR_A_SYSCTL0, 8'h00);
        chk({6'h00, div_out1_en_o, div_out0_en_o}, 8'h00);
        chk({5'h00, xtal_low_power_o, slow_clock_sel_o, fast_rc_run_o}, 8'h01);
    endtask

    task automatic t_banks();
        wr(`CSR_A_BANK, 8'hFF);
        rd_chk(`CSR_A_BANK, 8'h01);
        wr(`CSR_A_BANK, 8'h00);
        wr(`CSR_A_PTR_ZERO, 8'h40);
        wr(`CSR_A_PTR_ONE, 8'h40);
        wr(`CSR_A_IND_ZERO, 8'hAA);
        wr(`CSR_A_BANK, 8'h01);
        wr(`CSR_A_IND_ONE, 8'h55);
        rd_chk(`CSR_A_GP_BASE, 8'hAA);
        rd_chk(`CSR_A_IND_ONE, 8'h55);
        rd_chk(`CSR_A_IND_ZERO, 8'hAA);
        wr(`CSR_A_SYSCTL0, 8'h05);
        rd_chk(`CSR_A_SYSCTL0, 8'h05);
        wr(`CSR_A_BANK, 8'h00);
        rd_chk(`CSR_A_IND_ONE, 8'hAA);
        rd_chk(7'h30, 8'h00);
    endtask

    // A step taken during the dummy cycle is swallowed
    task automatic t_jump();
        wr(`CSR_A_PC_L, 8'hFF);
        pc_step_i <= 1'b1;
        #1;
        chk(pc_o[7:0], 8'hFF);
        chk({6'h00, jump_o, dummy_cycle_o}, 8'h02);
        @(posedge mclk_i);
        #1;
        chk({6'h00, jump_o, dummy_cycle_o}, 8'h01);
        @(posedge mclk_i);
        pc_step_i <= 1'b0;
        #1;
        chk({6'h00, pc_o[9:8]}, 8'h01);
        chk(pc_o[7:0], 8'h00);
        wr(`CSR_A_PC_L, 8'h55);
        #1;
        chk(pc_o[7:0], 8'h55);
        chk({6'h00, pc_o[9:8]}, 8'h01);
    endtask

    task automatic t_flags();
        wr(`CSR_A_FLAGS, 8'hFF);
        rd_chk(`CSR_A_FLAGS, 8'h0F);
        alu(CSR_ALU_ADD, 8'h7F, 8'h01);
        rd_chk(`CSR_A_FLAGS, 8'h0A);
        alu(CSR_ALU_ADD, 8'hFF, 8'h01);
        rd_chk(`CSR_A_FLAGS, 8'h07);
        alu(CSR_ALU_SUB, 8'h05, 8'h05);
        rd_chk(`CSR_A_FLAGS, 8'h07);
        alu(CSR_ALU_LOGIC, 8'h01, 8'h00);
        rd_chk(`CSR_A_FLAGS, 8'h03);
        alu(CSR_ALU_RLC, 8'h00, 8'h00);
        rd_chk(`CSR_A_FLAGS, 8'h02);
        alu(CSR_ALU_RRC, 8'h01, 8'h00);
        rd_chk(`CSR_A_FLAGS, 8'h03);
        ev(4'h8, 1'b0);
        wr(`CSR_A_FLAGS, 8'h00);
        rd_chk(`CSR_A_FLAGS, 8'h20);
        ev(4'h2, 1'b0);
        rd_chk(`CSR_A_FLAGS, 8'h10);
        ev(4'h4, 1'b0);
        rd_chk(`CSR_A_FLAGS, 8'h00);
        ev(4'hC, 1'b0);
        rd_chk(`CSR_A_FLAGS, 8'h20);
    endtask

    task automatic t_ports();
        wr(`CSR_A_PORT_A_DIR, 8'h0F);
        wr(`CSR_A_PORT_A, 8'hA5);
        settle();
        chk(pa_oe_o, 8'hF0);
        chk(pa_out_o, 8'hA5);
        repeat (4) @(posedge mclk_i);
        rd_chk(`CSR_A_PORT_A, 8'hAC);
        bitop(`CSR_A_PORT_A_DIR, 3'h7, 1'b1);
        bitop(`CSR_A_PORT_A, 3'h0, 1'b0);
        settle();
        chk(pa_oe_o, 8'h70);
        chk(pa_out_o, 8'hA4);
        bitop(`CSR_A_PORT_B_DIR, 3'h2, 1'b0);
        bitop(`CSR_A_PORT_B, 3'h2, 1'b1);
        settle();
        chk(pb_oe_o, 8'h04);
        chk(pb_out_o, 8'h04);
        rd_chk(`CSR_A_PORT_B, 8'h04);
    endtask

    // Reserved divider code keeps both outputs off
    task automatic t_ctrl();
        logic [7:0] exp_div [4];
        exp_div = '{8'h00, 8'h00, 8'h01, 8'h03};
        for (int i = 0; i < 4; i++) begin
            wr(`CSR_A_SYSCTL0, 8'(i << 2));
            settle();
            chk({6'h00, div_out1_en_o, div_out0_en_o}, exp_div[i]);
        end
        wr(`CSR_A_SYSCTL0, 8'hFF);
        rd_chk(`CSR_A_SYSCTL0, 8'h0F);
        settle();
        chk({5'h00, xtal_low_power_o, slow_clock_sel_o, fast_rc_run_o}, 8'h06);
    endtask

    task automatic t_soft_reset();
        wr(`CSR_A_BANK, 8'h01);
        ev(4'h1, 1'b1);
        rd_chk(`CSR_A_BANK, 8'h01);
        ev(4'h1, 1'b0);
        rd_chk(`CSR_A_BANK, 8'h00);
    endtask

    // ****************************************************************
    // Clock, reset, sequence and hang limit
    // ****************************************************************
    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end

    initial begin
        reset_i = 1'b1;
        {wr_i, rd_i, bit_op_i, bit_set_i, alu_valid_i, pc_step_i} = 6'h00;
        {wdt_timeout_i, clrwdt_i, stop_i, soft_reset_i, soft_reset_wdt_lp_i} = 5'h00;
        addr_i = 7'h00;
        bit_addr_i = 7'h00;
        bit_pos_i = 3'h0;
        wdata_i = 8'h00;
        alu_kind_i = CSR_ALU_ADD;
        alu_a_i = 8'h00;
        alu_b_i = 8'h00;
        pa_pin_i = 8'h3C;
        pb_pin_i = 8'h00;
        repeat (8) @(posedge mclk_i);
        reset_i <= 1'b0;
        t_reset();
        t_banks();
        t_jump();
        t_flags();
        t_ports();
        t_ctrl();
        t_soft_reset();
        finish_test();
    end

    // Cuts a hung run short
    initial begin
        repeat (20000) @(posedge mclk_i);
        miscompares++;
        finish_test();
    end
endmodule

`default_nettype wire
